// ===== acc_map.vh
// Purpose: register offsets, field positions, reset values and codes for the comparator control block
// Assumes: byte-wide register port, 8-bit addresses
// Notes: definitions only, no logic
`ifndef ACC_MAP_VH
`define ACC_MAP_VH

// register offsets
`define ACC_OFS_CTRL 8'h00
`define ACC_OFS_EVT 8'h01
`define ACC_OFS_MSK 8'h02

// control and status field positions
`define ACC_CTRL_PWR_OFF 7
`define ACC_CTRL_RSVD 6
`define ACC_CTRL_RESULT 5
`define ACC_CTRL_FLAG 4
`define ACC_CTRL_IEN 3
`define ACC_CTRL_ROUTE 2
`define ACC_CTRL_MODE_HI 1
`define ACC_CTRL_MODE_LO 0

// interrupt mode codes
`define ACC_MODE_TOGGLE 2'h0
`define ACC_MODE_RSVD 2'h1
`define ACC_MODE_FALL 2'h2
`define ACC_MODE_RISE 2'h3

// event status and mask field positions
`define ACC_EVT_RISE 0
`define ACC_EVT_FALL 1
`define ACC_EVT_FLAG 2
`define ACC_EVT_USED 8'h07

// reset values
`define ACC_CTRL_RST 8'h00
`define ACC_EVT_RST 8'h00
`define ACC_MSK_RST 8'h00
`define ACC_RDATA_IDLE 8'h00

`endif

// ===== acc_sync.v
// Purpose: bring the comparator output into the clock domain and keep one older sample
// Assumes: async_in may change at any time
// Notes: only the second stage and the older sample leave this module
`timescale 1ns/10ps
`default_nettype none

module acc_sync (
  input wire clock,
  input wire rstn,
  input wire async_in,
  output wire level,
  output wire level_prev
);

  reg meta_q;
  reg sync_q;
  reg prev_q;

  // first stage feeds the second stage only
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign level_prev = prev_q;

endmodule // acc_sync

`default_nettype wire

// ===== acc_top.v
// Purpose: control, status and interrupt logic around an on-chip voltage comparator
// Assumes: cmp_raw is the analog comparator's digital output, asynchronous to clock;
//          cpu_irq_global and vector_taken come from logic on the same clock
// Notes: one control and status register plus an event status and mask pair;
//        all outputs are flip-flops
`timescale 1ns/10ps
`default_nettype none

`include "acc_map.vh"

module acc_top (
  input wire clock,
  input wire rstn,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [7:0] reg_rdata,
  input wire cmp_raw,
  input wire cpu_irq_global,
  input wire vector_taken,
  output wire cmp_power_off,
  output wire cmp_irq_req,
  output wire capture_src,
  output wire irq
);

  // mode decode, used for the flag and for the event status
  function mode_match;
    input [1:0] mode;
    input rise;
    input fall;
    begin
      case (mode)
        `ACC_MODE_TOGGLE: mode_match = rise | fall;
        `ACC_MODE_FALL: mode_match = fall;
        `ACC_MODE_RISE: mode_match = rise;
        default: mode_match = 1'b0;
      endcase
    end
  endfunction

  // address decode, used by both strobes
  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  // reset image of the control register, taken apart per field
  localparam [7:0] CTRL_RST = `ACC_CTRL_RST;

  wire cmp_level;
  wire cmp_level_prev;
  wire cmp_result;
  wire cmp_rise;
  wire cmp_fall;
  wire mode_event;
  wire wr_ctrl;
  wire wr_msk;
  wire rd_ctrl;
  wire rd_evt;
  wire rd_msk;
  wire [7:0] ctrl_view;

  reg pwr_off_q;
  reg pwr_off_d;
  reg flag_q;
  reg flag_d;
  reg ien_q;
  reg ien_d;
  reg route_q;
  reg route_d;
  reg [1:0] mode_q;
  reg [1:0] mode_d;
  reg [7:0] evt_q;
  reg [7:0] evt_d;
  reg [7:0] msk_q;
  reg [7:0] msk_d;
  reg [7:0] rdata_q;
  reg [7:0] rdata_d;
  reg irq_req_q;
  reg capture_q;
  reg irq_q;

  acc_sync u_sync (
    .clock(clock),
    .rstn(rstn),
    .async_in(cmp_raw),
    .level(cmp_level),
    .level_prev(cmp_level_prev)
  );

  // comparator output after synchronising; an unpowered comparator reads zero
  assign cmp_result = cmp_level & ~pwr_off_q;

  // edges from two consecutive synchronised samples
  assign cmp_rise = cmp_level & ~cmp_level_prev;
  assign cmp_fall = ~cmp_level & cmp_level_prev;

  // no events while powered off; the power change itself may still
  // produce one edge, which is why software disables first
  assign mode_event = mode_match(mode_q, cmp_rise, cmp_fall) & ~pwr_off_q;

  assign wr_ctrl = reg_wr & hit(reg_addr, `ACC_OFS_CTRL);
  assign wr_msk = reg_wr & hit(reg_addr, `ACC_OFS_MSK);
  assign rd_ctrl = reg_rd & hit(reg_addr, `ACC_OFS_CTRL);
  assign rd_evt = reg_rd & hit(reg_addr, `ACC_OFS_EVT);
  assign rd_msk = reg_rd & hit(reg_addr, `ACC_OFS_MSK);

  // live view of the control and status register
  assign ctrl_view = {pwr_off_q,
                      1'b0,
                      cmp_result,
                      flag_q,
                      ien_q,
                      route_q,
                      mode_q};

  // plain control bits
  always @* begin
    pwr_off_d = pwr_off_q;
    ien_d = ien_q;
    route_d = route_q;
    mode_d = mode_q;
    if (wr_ctrl) begin
      pwr_off_d = reg_wdata[`ACC_CTRL_PWR_OFF];
      ien_d = reg_wdata[`ACC_CTRL_IEN];
      route_d = reg_wdata[`ACC_CTRL_ROUTE];
      mode_d = reg_wdata[`ACC_CTRL_MODE_HI:`ACC_CTRL_MODE_LO];
    end
  end

  // interrupt flag: a new event beats a clear in the same cycle
  always @* begin
    flag_d = flag_q;
    if (vector_taken) begin
      flag_d = 1'b0;
    end
    if (wr_ctrl && reg_wdata[`ACC_CTRL_FLAG]) begin
      flag_d = 1'b0;
    end
    if (mode_event) begin
      flag_d = 1'b1;
    end
  end

  // sticky event status, cleared by reading it; set wins over the read
  always @* begin
    evt_d = evt_q;
    if (rd_evt) begin
      evt_d = `ACC_EVT_RST;
    end
    if (cmp_rise && !pwr_off_q) begin
      evt_d[`ACC_EVT_RISE] = 1'b1;
    end
    if (cmp_fall && !pwr_off_q) begin
      evt_d[`ACC_EVT_FALL] = 1'b1;
    end
    if (mode_event) begin
      evt_d[`ACC_EVT_FLAG] = 1'b1;
    end
  end

  // mask keeps only the implemented bits
  always @* begin
    msk_d = msk_q;
    if (wr_msk) begin
      msk_d = reg_wdata & `ACC_EVT_USED;
    end
  end

  // read data stand for exactly one cycle after the strobe
  always @* begin
    rdata_d = `ACC_RDATA_IDLE;
    if (rd_ctrl) begin
      rdata_d = ctrl_view;
    end else if (rd_evt) begin
      rdata_d = evt_q;
    end else if (rd_msk) begin
      rdata_d = msk_q;
    end
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pwr_off_q <= CTRL_RST[`ACC_CTRL_PWR_OFF];
      ien_q <= CTRL_RST[`ACC_CTRL_IEN];
      route_q <= CTRL_RST[`ACC_CTRL_ROUTE];
      mode_q <= CTRL_RST[`ACC_CTRL_MODE_HI:`ACC_CTRL_MODE_LO];
      flag_q <= CTRL_RST[`ACC_CTRL_FLAG];
      evt_q <= `ACC_EVT_RST;
      msk_q <= `ACC_MSK_RST;
      rdata_q <= `ACC_RDATA_IDLE;
    end else begin
      pwr_off_q <= pwr_off_d;
      ien_q <= ien_d;
      route_q <= route_d;
      mode_q <= mode_d;
      flag_q <= flag_d;
      evt_q <= evt_d;
      msk_q <= msk_d;
      rdata_q <= rdata_d;
    end
  end

  // outputs, all from flops
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq_req_q <= 1'b0;
      capture_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      // request drops the cycle after vector_taken, at the same edge as the flag, via flag_d
      irq_req_q <= flag_d & ien_d & cpu_irq_global;
      // gated to zero when not routed so the capture unit sees no activity
      capture_q <= route_d & cmp_result;
      irq_q <= |(evt_d & msk_d);
    end
  end

  assign cmp_power_off = pwr_off_q;
  assign cmp_irq_req = irq_req_q;
  assign capture_src = capture_q;
  assign irq = irq_q;
  assign reg_rdata = rdata_q;

endmodule // acc_top

`default_nettype wire

// ===== acc_cmp_model.sv
// Purpose: stand-in for the analog comparator
// Assumes: input levels in millivolts
// Notes: output held low while powered off
`timescale 1ns/10ps
`default_nettype none
module acc_cmp_model (
  input wire logic power_off,
  input var int pos_mv,
  input var int neg_mv,
  output logic cmp_raw
);
  assign cmp_raw = !power_off && (pos_mv > neg_mv);
endmodule // acc_cmp_model
`default_nettype wire

// ===== acc_top_sva.sv
// Purpose: port checks for acc_top
// Assumes: one clock, rstn low resets
// Notes: vector check needs cmp_raw quiet first
`timescale 1ns/10ps
`default_nettype none
module acc_top_sva (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic cmp_raw,
  input wire logic cpu_irq_global,
  input wire logic vector_taken,
  input wire logic cmp_power_off,
  input wire logic cmp_irq_req,
  input wire logic capture_src
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);
  sequence s_quiet;
    $stable(cmp_raw) [*4];
  endsequence
  sequence s_off;
    cmp_power_off [*4];
  endsequence
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("rdata not idle");
  chk_rsvd_zero: assert property ($past(reg_rd) && $past(reg_addr) == 8'h00 |-> !reg_rdata[6])
    else $error("reserved bit set");
  chk_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) > 8'h02 |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_power_write: assert property (reg_wr && reg_addr == 8'h00 |=> cmp_power_off == $past(reg_wdata[7]))
    else $error("power off not written");
  chk_global_gate: assert property (!cpu_irq_global |=> !cmp_irq_req) else $error("request without global");
  chk_vector_clear: assert property (s_quiet ##0 vector_taken |=> !cmp_irq_req)
    else $error("vector left request");
  chk_capture_cause: assert property ($rose(capture_src) |-> $past(cmp_raw, 3))
    else $error("capture rise without cause");
  chk_off_no_capture: assert property (s_off |-> !capture_src) else $error("capture while off");
endmodule // acc_top_sva
bind acc_top acc_top_sva acc_top_sva_inst (.clock, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .cmp_raw, .cpu_irq_global, .vector_taken, .cmp_power_off, .cmp_irq_req, .capture_src);
`default_nettype wire

// ===== tb_acc_top.sv
// Purpose: self-checking bench for acc_top
// Assumes: 200 MHz clock
// Notes: every mode cycled with random levels
`timescale 1ns/10ps
`default_nettype none
module tb_acc_top;
  logic clock = 0, rstn = 0, reg_wr = 0, reg_rd = 0, cpu_irq_global = 0, vector_taken = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, ctl = 8'h00, d;
  logic cmp_raw, cmp_power_off, cmp_irq_req, capture_src, irq;
  int pos_mv = 0, neg_mv = 0, flag = 0, res = 0, evt = 0, mask = 0, error_cnt = 0, total_checks = 0;
  always #2.5 clock = ~clock;
  acc_top acc_top_inst (.clock, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cmp_raw,
    .cpu_irq_global, .vector_taken, .cmp_power_off, .cmp_irq_req, .capture_src, .irq);
  acc_cmp_model acc_cmp_model_inst (.power_off(cmp_power_off), .pos_mv, .neg_mv, .cmp_raw);
  task automatic chk(input string n, input logic [7:0] s, e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, w);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    if (a == 8'h00) ctl = w & 8'h8F;
    if (a == 8'h00 && w[4]) flag = 0;
    if (a == 8'h02) mask = w & 8'h07;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // wait covers the two-stage sync plus the edge stage
  task automatic setv(input int hi);
    int p, r;
    p = $urandom % 900 + 100;
    @(posedge clock);
    pos_mv <= p;
    neg_mv <= hi ? p - 1 - $urandom % 50 : p + 1 + $urandom % 50;
    repeat (4) @(posedge clock);
    r = !ctl[7] && hi;
    if (r != res) begin
      evt |= r ? 1 : 2;
      if (ctl[1:0] == 0 || ctl[1:0] == 2 + r) begin
        flag = 1;
        evt |= 4;
      end
    end
    res = r;
  endtask
  task automatic check;
    rd(8'h00);
    chk("ctrl", d, ctl | res << 5 | flag << 4);
    chk("req", cmp_irq_req, flag & ctl[3] & cpu_irq_global);
    // capture unit itself is not modelled; its own enable stays with software
    chk("cap", capture_src, ctl[2] & res);
    chk("off", cmp_power_off, ctl[7]);
    chk("irq", irq, (evt & mask) != 0);
  endtask
  initial begin
    #100000;
    error_cnt++;
    wrap_up;
  end
  initial begin
    void'($urandom(33152));
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    for (int a = 0; a < 4; a++) begin
      rd(a == 3 ? 8'h05 : a);
      chk("reset", d, 8'h00);
    end
    wr(8'h02, 8'hFF);
    for (int m = 0; m < 4; m++) begin
      cpu_irq_global <= m != 2;
      wr(8'h00, m);
      // enable only after the mode is settled
      wr(8'h00, 8'h6C | m);
      for (int i = 0; i < 4; i++) begin
        setv(i % 2 == 0);
        check;
      end
      if (m[0]) begin
        @(posedge clock);
        vector_taken <= 1'b1;
        @(posedge clock);
        vector_taken <= 1'b0;
        flag = 0;
      end else
        wr(8'h00, 8'h1C | m);
      check;
      rd(8'h01);
      chk("evt", d, evt);
      evt = 0;
      check;
    end
    wr(8'h00, 8'h00);
    wr(8'h00, 8'h80);
    setv(1);
    check;
    setv(0);
    wr(8'h00, 8'h00);
    setv(1);
    check;
    wr(8'h02, 8'h00);
    check;
    wrap_up;
  end
endmodule // tb_acc_top
`default_nettype wire
